// ===== pkg/hfq_params.svh
// Purpose: Offsets, field positions, reset values and counts for the frame queue control
// Assumes: Included by design and verification files
// Notes:   Definitions only
`ifndef HFQ_PARAMS_SVH
`define HFQ_PARAMS_SVH

`define HFQ_OFF_TXCMD      8'h00
`define HFQ_OFF_RXCMD      8'h02
`define HFQ_OFF_TXPTR      8'h04
`define HFQ_OFF_TXFREE     8'h08
`define HFQ_OFF_RXPEND     8'h0a
`define HFQ_OFF_DATA       8'h0c
`define HFQ_OFF_RXFRAME    8'h0e

`define HFQ_CMD_BIT        0
`define HFQ_AUTOINC_BIT    14
`define HFQ_PTR_MSB        10
`define HFQ_CNT_MSB        12
`define HFQ_RXIE_BIT       13

`define HFQ_TXQ_BYTES      13'h0800
`define HFQ_RXQ_BYTES      13'h1000
`define HFQ_CTRL_BYTES     13'h0004
`define HFQ_STAT_BYTES     13'h0004
`define HFQ_PTR_RESET      11'h000

`define HFQ_APB_OFF_ADDR   8'h00
`define HFQ_APB_OFF_WDATA  8'h04
`define HFQ_APB_OFF_CTRL   8'h08
`define HFQ_APB_OFF_STAT   8'h0c
`define HFQ_APB_OFF_RDATA  8'h10

`endif

// ===== pkg/hfq_pkg.sv
// Purpose: Shared types for the frame queue control
// Assumes: hfq_params.svh holds the numbers
// Notes:   Types only
package hfq_pkg;
    typedef enum logic [1:0] {
        HFQ_SZ_BYTE  = 2'h0,
        HFQ_SZ_WORD  = 2'h1,
        HFQ_SZ_DWORD = 2'h2
    } hfq_size_t;

    typedef enum logic [3:0] {
        HFQ_H_IDLE   = 4'h1,
        HFQ_H_REQ    = 4'h2,
        HFQ_H_WAIT   = 4'h4,
        HFQ_H_DONE   = 4'h8
    } hfq_hstate_t;
endpackage

// ===== pkg/hfq_if.sv
// Purpose: Register-bus link between host controller and queue device
// Assumes: Single clock, one access per strobe
// Notes:   Device answers with ack one cycle after req
`timescale 1ns/1ps
`default_nettype none
interface hfq_if;
    import hfq_pkg::*;
    logic        req;
    logic        wr;
    logic [7:0]  addr;
    hfq_size_t   size;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ack;

    modport dev  (input req, input wr, input addr, input size, input wdata,
                  output rdata, output ack);
    modport host (output req, output wr, output addr, output size, output wdata,
                  input rdata, input ack);
endinterface
`default_nettype wire

// ===== hdl/hfq_device.sv
// Purpose: Queue manager host-side control: free space, pending bytes, commands, tx pointer
// Assumes: Host keeps one request open until ack; frame side is same-clock logic
// Notes:   Reads of the data window return the head frame size; writes land at the tx pointer
`timescale 1ns/1ps
`default_nettype none
`include "hfq_params.svh"

// Notes on behaviour
// - Tx free space, bits 12:0, bytes
// - Free space counts payload plus control word
// - Host checks space before writing frame
// - Rx pending, bits 12:0, includes status words
// - Receive queue holds 4096 bytes
// - Pending updates on full packet; interrupt if enabled
// - Host drains; device drops frames not fitting
// - Enqueue bit write one queues frame
// - Enqueue bit clears after transmit done
// - Host waits enqueue clear before next frame
// - Release bit write one frees frame
// - Release bit clears once memory freed
// - Host polls release clear before next frame
// - Autoadvance adds 1, 2 or 4
// - Only data writes advance pointer
// - Without autoadvance pointer holds written value
// - Pointer 10:0 holds its value after enqueue
// - Data writes to tx queue, reads from rx
module hfq_device
    import hfq_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    hfq_if.dev               bus,
    input  wire logic        rx_frame_done_i,
    input  wire logic [12:0] rx_frame_len_i,
    input  wire logic        tx_frame_sent_i,
    input  wire logic        rxie_i,
    output logic             tx_start_o,
    output logic [12:0]      tx_frame_len_o,
    output logic             tx_wr_o,
    output logic [10:0]      tx_wr_addr_o,
    output logic [31:0]      tx_wr_data_o,
    output logic [1:0]       tx_wr_size_o,
    output logic             rx_drop_o,
    output logic             rx_irq_o
);
    logic        enq_reg;
    logic        rel_reg;
    logic        autoinc_reg;
    logic [10:0] ptr_reg;
    logic [10:0] frame_base_reg;
    logic [12:0] txfree_reg;
    logic [12:0] rxpend_reg;
    logic [12:0] rxused_reg;
    // Lengths of accepted frames, oldest first; a full list drops like a full queue
    logic [12:0] len_mem [0:15];
    logic [3:0]  len_wr_reg;
    logic [3:0]  len_rd_reg;
    logic [4:0]  len_cnt_reg;
    logic [31:0] rdata_reg;
    logic        ack_reg;
    logic        tx_start_reg;
    logic [12:0] tx_len_reg;
    logic        tx_wr_reg;
    logic [10:0] tx_addr_reg;
    logic [31:0] tx_data_reg;
    logic [1:0]  tx_size_reg;
    logic        rx_drop_reg;
    logic        rx_irq_reg;

    wire         acc      = bus.req & ~ack_reg;
    wire         wr_acc   = acc & bus.wr;
    wire         cmd_one  = bus.wdata[`HFQ_CMD_BIT];
    wire         wr_enq   = wr_acc & (bus.addr == `HFQ_OFF_TXCMD) & cmd_one & ~enq_reg;
    wire         wr_rel   = wr_acc & (bus.addr == `HFQ_OFF_RXCMD) & cmd_one & ~rel_reg;
    wire         wr_ptr   = wr_acc & (bus.addr == `HFQ_OFF_TXPTR);
    wire         wr_data  = wr_acc & (bus.addr == `HFQ_OFF_DATA);
    wire [10:0]  step     = (bus.size == HFQ_SZ_BYTE) ? 11'h001 :
                            (bus.size == HFQ_SZ_WORD) ? 11'h002 : 11'h004;
    wire [10:0]  frame_len = ptr_reg - frame_base_reg;
    // Packet plus its status word must fit whole, or it is dropped
    wire [13:0]  rx_need  = {1'b0, rx_frame_len_i} + {1'b0, `HFQ_STAT_BYTES};
    wire [13:0]  rx_room  = {1'b0, `HFQ_RXQ_BYTES} - {1'b0, rxused_reg};
    wire         rx_fits  = (rx_need <= rx_room) & ~len_cnt_reg[4];
    wire         rx_take  = rx_frame_done_i & rx_fits;
    wire [12:0]  rx_head  = (len_cnt_reg == 5'h00) ? 13'h0000 : len_mem[len_rd_reg];
    wire [12:0]  rx_rel_len = (rx_head > rxpend_reg) ? rxpend_reg : rx_head;
    wire [12:0]  rx_add   = rx_take ? rx_need[12:0] : 13'h0000;
    wire [12:0]  rx_sub   = rel_reg ? rx_rel_len : 13'h0000;
    wire [4:0]   cnt_add  = {4'h0, rx_take};
    wire [4:0]   cnt_sub  = {4'h0, rel_reg & (len_cnt_reg != 5'h00)};

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (bus.addr)
            `HFQ_OFF_TXCMD:  rd_mux[`HFQ_CMD_BIT] = enq_reg;
            `HFQ_OFF_RXCMD:  rd_mux[`HFQ_CMD_BIT] = rel_reg;
            `HFQ_OFF_TXPTR:  rd_mux = {17'h0, autoinc_reg, 3'h0, ptr_reg};
            `HFQ_OFF_TXFREE: rd_mux = {19'h0, txfree_reg};
            `HFQ_OFF_RXPEND: rd_mux = {19'h0, rxpend_reg};
            `HFQ_OFF_DATA:   rd_mux = {19'h0, rx_head};
            default:         rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= acc;
            rdata_reg <= acc ? rd_mux : rdata_reg;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enq_reg      <= 1'b0;
            tx_start_reg <= 1'b0;
            tx_len_reg   <= 13'h0000;
        end else begin
            tx_start_reg <= wr_enq;
            if (wr_enq) begin
                enq_reg    <= 1'b1;
                tx_len_reg <= {2'b00, frame_len};
            end else if (tx_frame_sent_i) begin
                enq_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            txfree_reg <= `HFQ_TXQ_BYTES;
        end else if (wr_enq) begin
            txfree_reg <= txfree_reg - {2'b00, frame_len} - `HFQ_CTRL_BYTES;
        end else if (tx_frame_sent_i & enq_reg) begin
            txfree_reg <= `HFQ_TXQ_BYTES;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ptr_reg        <= `HFQ_PTR_RESET;
            frame_base_reg <= `HFQ_PTR_RESET;
            autoinc_reg    <= 1'b0;
        end else if (wr_enq) begin
            ptr_reg        <= ptr_reg;
            frame_base_reg <= ptr_reg;
        end else if (wr_ptr) begin
            ptr_reg     <= bus.wdata[`HFQ_PTR_MSB:0];
            autoinc_reg <= bus.wdata[`HFQ_AUTOINC_BIT];
        end else if (wr_data & autoinc_reg) begin
            ptr_reg <= ptr_reg + step;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_wr_reg   <= 1'b0;
            tx_addr_reg <= 11'h000;
            tx_data_reg <= 32'h0000_0000;
            tx_size_reg <= 2'h0;
        end else begin
            tx_wr_reg <= wr_data;
            if (wr_data) begin
                tx_addr_reg <= ptr_reg;
                tx_data_reg <= bus.wdata;
                tx_size_reg <= bus.size;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rel_reg     <= 1'b0;
            rxpend_reg  <= 13'h0000;
            rxused_reg  <= 13'h0000;
            len_wr_reg  <= 4'h0;
            len_rd_reg  <= 4'h0;
            len_cnt_reg <= 5'h00;
            rx_drop_reg <= 1'b0;
            rx_irq_reg  <= 1'b0;
        end else begin
            rx_drop_reg <= rx_frame_done_i & ~rx_fits;
            rx_irq_reg  <= rx_take & rxie_i;
            // Arrival and release may share a cycle; both take effect
            rxpend_reg  <= rxpend_reg + rx_add - rx_sub;
            rxused_reg  <= rxused_reg + rx_add - rx_sub;
            len_cnt_reg <= len_cnt_reg + cnt_add - cnt_sub;
            if (rx_take) begin
                len_wr_reg <= len_wr_reg + 4'h1;
            end
            if (cnt_sub[0]) begin
                len_rd_reg <= len_rd_reg + 4'h1;
            end
            // Set one cycle by the write, then cleared as memory is freed
            rel_reg     <= wr_rel;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rx_take) begin
            len_mem[len_wr_reg] <= rx_need[12:0];
        end
    end

    assign bus.ack        = ack_reg;
    assign bus.rdata      = rdata_reg;
    assign tx_start_o     = tx_start_reg;
    assign tx_frame_len_o = tx_len_reg;
    assign tx_wr_o        = tx_wr_reg;
    assign tx_wr_addr_o   = tx_addr_reg;
    assign tx_wr_data_o   = tx_data_reg;
    assign tx_wr_size_o   = tx_size_reg;
    assign rx_drop_o      = rx_drop_reg;
    assign rx_irq_o       = rx_irq_reg;
endmodule
`default_nettype wire

// ===== hdl/hfq_host.sv
// Purpose: Host controller: APB slave that runs single accesses on the queue link
// Assumes: Software checks space and polls command bits
// Notes:   One access in flight; status shows busy, read data register shows data returned by the last access, read or write
`timescale 1ns/1ps
`default_nettype none
`include "hfq_params.svh"
module hfq_host
    import hfq_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    hfq_if.host              bus
);
    hfq_hstate_t state_reg;
    logic [7:0]  addr_reg;
    logic [31:0] wdata_reg;
    logic        wr_reg;
    hfq_size_t   size_reg;
    logic [31:0] rdata_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;

    wire setup    = psel & ~penable & ~pready_reg;
    wire hit_addr = setup & (paddr == `HFQ_APB_OFF_ADDR);
    wire hit_wd   = setup & (paddr == `HFQ_APB_OFF_WDATA);
    wire hit_ctrl = setup & (paddr == `HFQ_APB_OFF_CTRL);
    wire hit_stat = setup & (paddr == `HFQ_APB_OFF_STAT);
    wire hit_rd   = setup & (paddr == `HFQ_APB_OFF_RDATA);
    wire busy     = (state_reg != HFQ_H_IDLE);
    wire go       = hit_ctrl & pwrite & pwdata[0] & ~busy;
    wire bad      = setup & ~(hit_addr | hit_wd | hit_ctrl | hit_stat | hit_rd);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_addr) rd_mux = {24'h0, addr_reg};
        if (hit_wd)   rd_mux = wdata_reg;
        if (hit_ctrl) rd_mux = {28'h0, size_reg, wr_reg, 1'b0};
        if (hit_stat) rd_mux = {31'h0, busy};
        if (hit_rd)   rd_mux = rdata_reg;
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= bad;
            prdata_reg  <= setup ? rd_mux : prdata_reg;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            addr_reg  <= 8'h00;
            wdata_reg <= 32'h0000_0000;
            wr_reg    <= 1'b0;
            size_reg  <= HFQ_SZ_WORD;
        end else begin
            if (hit_addr & pwrite & ~busy) addr_reg <= pwdata[7:0];
            if (hit_wd & pwrite & ~busy)   wdata_reg <= pwdata;
            if (go) begin
                wr_reg   <= pwdata[1];
                size_reg <= hfq_size_t'(pwdata[3:2]);
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= HFQ_H_IDLE;
            rdata_reg <= 32'h0000_0000;
        end else begin
            unique case (state_reg)
                HFQ_H_IDLE: if (go) state_reg <= HFQ_H_REQ;
                HFQ_H_REQ:  state_reg <= HFQ_H_WAIT;
                HFQ_H_WAIT: if (bus.ack) begin
                    rdata_reg <= bus.rdata;
                    state_reg <= HFQ_H_DONE;
                end
                HFQ_H_DONE: state_reg <= HFQ_H_IDLE;
                default:    state_reg <= HFQ_H_IDLE;
            endcase
        end
    end

    // Request held from REQ until ack seen
    assign bus.req   = (state_reg == HFQ_H_REQ) | (state_reg == HFQ_H_WAIT);
    assign bus.wr    = wr_reg;
    assign bus.addr  = addr_reg;
    assign bus.size  = size_reg;
    assign bus.wdata = wdata_reg;
    assign prdata    = prdata_reg;
    assign pready    = pready_reg;
    assign pslverr   = pslverr_reg;
endmodule
`default_nettype wire

// ===== verif/hfq_link_chk.sv
// Purpose: Checks the queue link between host controller and queue device
// Assumes: Signals taken straight from the link interface
// Notes:   One clock domain, reset low disables checks
`timescale 1ns/1ps
`default_nettype none
`include "hfq_params.svh"
module hfq_link_chk
    import hfq_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        resetn_i,
    input wire logic        req,
    input wire logic        wr,
    input wire logic [7:0]  addr,
    input wire hfq_size_t   size,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        ack
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    wire rd_go;
    // Read taken now, answer lands with ack next cycle
    assign rd_go = req && !ack && !wr;

    chk_ack_next: assert property (req && !ack |=> ack)
        else $error("ack missing after request");
    chk_ack_single: assert property (ack |=> !ack && !req)
        else $error("ack or request held too long");
    chk_ack_cause: assert property (ack |-> $past(req))
        else $error("ack without request");
    chk_req_hold: assert property (req && !ack |=> $stable(addr) && $stable(wr)
        && $stable(wdata) && $stable(size))
        else $error("request changed before ack");
    chk_txfree_field: assert property (rd_go && addr == `HFQ_OFF_TXFREE |=>
        rdata[31:13] == 19'h0 && rdata[12:0] <= `HFQ_TXQ_BYTES)
        else $error("tx free space out of range");
    chk_rxpend_field: assert property (rd_go && addr == `HFQ_OFF_RXPEND |=>
        rdata[31:13] == 19'h0 && rdata[12:0] <= `HFQ_RXQ_BYTES)
        else $error("rx pending out of range");
    chk_cmd_reserved: assert property (rd_go && (addr == `HFQ_OFF_TXCMD
        || addr == `HFQ_OFF_RXCMD) |=> rdata[31:1] == 31'h0)
        else $error("command reserved bits set");
    chk_ptr_reserved: assert property (rd_go && addr == `HFQ_OFF_TXPTR |=>
        rdata[31:15] == 17'h0 && rdata[13:11] == 3'h0)
        else $error("pointer reserved bits set");
endmodule
`default_nettype wire

// ===== verif/host_frame_queue_control_test.sv
// Purpose: Self-checking bench for host controller and queue device together
// Assumes: Software side speaks APB to the controller
// Notes:   Frame side pulses driven by the bench
`timescale 1ns/1ps
`default_nettype none
`include "hfq_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error at %0t: got %h want %h", $time, (a), (b)); end end
module host_frame_queue_control_test
    import hfq_pkg::*;
;
    logic        clk_i, resetn_i, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, wr_data;
    logic        rx_done, tx_sent, rxie, tx_start, tx_wr, rx_drop, rx_irq;
    logic [12:0] rx_len, tx_len, len_cap;
    logic [10:0] tx_wr_addr, wr_addr;
    logic [31:0] tx_wr_data;
    logic [1:0]  tx_wr_size, wr_size;
    int          error_cnt, check_count, wr_cnt, start_cnt, irq_cnt, drop_cnt;
    hfq_if link_if();
    hfq_device hfq_device_inst(.clk_i(clk_i), .resetn_i(resetn_i), .bus(link_if),
        .rx_frame_done_i(rx_done), .rx_frame_len_i(rx_len), .tx_frame_sent_i(tx_sent),
        .rxie_i(rxie), .tx_start_o(tx_start), .tx_frame_len_o(tx_len), .tx_wr_o(tx_wr),
        .tx_wr_addr_o(tx_wr_addr), .tx_wr_data_o(tx_wr_data), .tx_wr_size_o(tx_wr_size),
        .rx_drop_o(rx_drop), .rx_irq_o(rx_irq));
    hfq_host hfq_host_inst(.clk_i(clk_i), .resetn_i(resetn_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link_if));
    hfq_link_chk hfq_link_chk_inst(.clk_i(clk_i), .resetn_i(resetn_i), .req(link_if.req),
        .wr(link_if.wr), .addr(link_if.addr), .size(link_if.size), .wdata(link_if.wdata),
        .rdata(link_if.rdata), .ack(link_if.ack));
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Frame-side monitor keeps counts of pulses
    always @(posedge clk_i) begin
        if (tx_wr === 1'b1) begin
            wr_cnt++;
            wr_addr = tx_wr_addr;
            wr_data = tx_wr_data;
            wr_size = tx_wr_size;
        end
        if (tx_start === 1'b1) begin
            start_cnt++;
            len_cap = tx_len;
        end
        if (rx_irq === 1'b1) irq_cnt++;
        if (rx_drop === 1'b1) drop_cnt++;
    end
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_i);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // No wait limit here; the watchdog ends a hang
        do begin @(posedge clk_i); end while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic link(input logic w, input logic [7:0] a, input hfq_size_t sz,
                        input logic [31:0] d, output logic [31:0] q);
        apb(1'b1, `HFQ_APB_OFF_ADDR, {24'h0, a}, q);
        apb(1'b1, `HFQ_APB_OFF_WDATA, d, q);
        apb(1'b1, `HFQ_APB_OFF_CTRL, {28'h0, sz, w, 1'b1}, q);
        do begin apb(1'b0, `HFQ_APB_OFF_STAT, 32'h0, q); end
        while (q[0] !== 1'b0);
        apb(1'b0, `HFQ_APB_OFF_RDATA, 32'h0, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        link(1'b0, a, HFQ_SZ_WORD, 32'h0, q);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        link(1'b1, a, HFQ_SZ_WORD, d, q);
    endtask
    task automatic pulse(input logic t, input logic [12:0] len, input logic ie);
        @(posedge clk_i);
        tx_sent <= t; rx_done <= !t; rx_len <= len; rxie <= ie;
        @(posedge clk_i);
        tx_sent <= 1'b0; rx_done <= 1'b0;
        // Let the answering pulse reach the monitor's counts
        repeat (2) @(posedge clk_i);
    endtask
    task automatic t_reset;
        logic [31:0] q;
        rd(`HFQ_OFF_TXFREE, q); `CHK(q[15:0], 16'h0800)
        rd(`HFQ_OFF_RXPEND, q); `CHK(q[15:0], 16'h0000)
        rd(`HFQ_OFF_TXCMD, q); `CHK(q[15:0], 16'h0000)
        rd(`HFQ_OFF_TXPTR, q); `CHK(q[15:0], 16'h0000)
        apb(1'b0, 8'h20, 32'h0, q); `CHK(last_err, 1'b1)
        $display("reset test done");
    endtask
    task automatic t_ptr;
        logic [31:0] q;
        rd(`HFQ_OFF_TXFREE, q); `CHK(q[12:0], 13'h0800)
        wr(`HFQ_OFF_TXPTR, 32'h4010);
        link(1'b1, `HFQ_OFF_DATA, HFQ_SZ_BYTE, 32'h11, q); `CHK(wr_addr, 11'h010)
        link(1'b1, `HFQ_OFF_DATA, HFQ_SZ_WORD, 32'h2222, q); `CHK(wr_addr, 11'h011)
        link(1'b1, `HFQ_OFF_DATA, HFQ_SZ_DWORD, 32'h4444, q); `CHK(wr_addr, 11'h013)
        `CHK(wr_data, 32'h4444)
        `CHK(wr_size, 2'h2)
        link(1'b0, `HFQ_OFF_DATA, HFQ_SZ_DWORD, 32'h0, q); `CHK(wr_cnt, 3)
        rd(`HFQ_OFF_TXPTR, q); `CHK(q[15:0], 16'h4017)
        wr(`HFQ_OFF_TXPTR, 32'hffff);
        rd(`HFQ_OFF_TXPTR, q); `CHK(q[15:0], 16'h47ff)
        wr(`HFQ_OFF_TXPTR, 32'h0020);
        link(1'b1, `HFQ_OFF_DATA, HFQ_SZ_WORD, 32'h5555, q); `CHK(wr_addr, 11'h020)
        rd(`HFQ_OFF_TXPTR, q); `CHK(q[15:0], 16'h0020)
        $display("pointer test done");
    endtask
    task automatic t_tx;
        logic [31:0] q;
        wr(`HFQ_OFF_TXCMD, 32'h0); `CHK(start_cnt, 0)
        wr(`HFQ_OFF_TXCMD, 32'h1); `CHK(start_cnt, 1)
        rd(`HFQ_OFF_TXCMD, q); `CHK(q[15:0], 16'h0001)
        rd(`HFQ_OFF_TXFREE, q); `CHK(q[12:0], 13'h07dc)
        `CHK(len_cap, 13'h0020)
        wr(`HFQ_OFF_TXCMD, 32'h1); `CHK(start_cnt, 1)
        rd(`HFQ_OFF_TXPTR, q); `CHK(q[10:0], 11'h020)
        pulse(1'b1, 13'h0, 1'b0);
        rd(`HFQ_OFF_TXCMD, q); `CHK(q[15:0], 16'h0000)
        rd(`HFQ_OFF_TXFREE, q); `CHK(q[12:0], 13'h0800)
        $display("enqueue test done");
    endtask
    task automatic t_rx;
        logic [31:0] q;
        pulse(1'b0, 13'd60, 1'b1);
        rd(`HFQ_OFF_RXPEND, q); `CHK(q[15:0], 16'd64)
        `CHK(irq_cnt, 1)
        pulse(1'b0, 13'd100, 1'b0);
        rd(`HFQ_OFF_RXPEND, q); `CHK(q[15:0], 16'd168)
        `CHK(irq_cnt, 1)
        wr(`HFQ_OFF_RXCMD, 32'h0);
        rd(`HFQ_OFF_RXPEND, q); `CHK(q[15:0], 16'd168)
        wr(`HFQ_OFF_RXCMD, 32'h1);
        rd(`HFQ_OFF_RXCMD, q); `CHK(q[15:0], 16'h0000)
        rd(`HFQ_OFF_RXPEND, q); `CHK(q[15:0], 16'd104)
        rd(`HFQ_OFF_DATA, q); `CHK(q[12:0], 13'd104)
        // One byte over capacity must be dropped
        pulse(1'b0, 13'd3989, 1'b0); `CHK(drop_cnt, 1)
        rd(`HFQ_OFF_RXPEND, q); `CHK(q[15:0], 16'd104)
        pulse(1'b0, 13'd3988, 1'b0);
        rd(`HFQ_OFF_RXPEND, q); `CHK(q[15:0], 16'h1000)
        `CHK(drop_cnt, 1)
        $display("receive test done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #1000000;
        error_cnt++;
        tally_and_finish;
    end
    initial begin
        {psel, penable, pwrite, rx_done, tx_sent, rxie} = 6'h0;
        paddr = 8'h0; pwdata = 32'h0; rx_len = 13'h0; resetn_i = 1'b0;
        repeat (5) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_reset;
        t_ptr;
        t_tx;
        t_rx;
        tally_and_finish;
    end
endmodule
`default_nettype wire
